// ==== rtl/icfgt_cfg.svh ====
// constants of the two-wire configuration target: timing, offsets, fields, resets
// assumes one 40 MHz clock; included by bare name where needed
`ifndef ICFGT_CFG_SVH
`define ICFGT_CFG_SVH

// clock and documented times
`define ICFGT_CLK_MHZ       40
`define ICFGT_PG_DELAY_US   500
`define ICFGT_STRAP_SU_US   250
`define ICFGT_STRAP_HD_US   10
`define ICFGT_DEBOUNCE_MS   16
`define ICFGT_PG_CYCLES     (`ICFGT_PG_DELAY_US * `ICFGT_CLK_MHZ)
`define ICFGT_SU_CYCLES     (`ICFGT_STRAP_SU_US * `ICFGT_CLK_MHZ)
`define ICFGT_DB_CYCLES     (`ICFGT_DEBOUNCE_MS * 1000 * `ICFGT_CLK_MHZ)
`define ICFGT_SYNC_LAT      3

// register offsets
`define ICFGT_OFS_GENERAL   8'h0A
`define ICFGT_OFS_DPEQ01    8'h10
`define ICFGT_OFS_DPEQ23    8'h11
`define ICFGT_OFS_LSTAT     8'h12
`define ICFGT_OFS_EVENT     8'h20

// general register fields
`define ICFGT_GEN_CTL_LSB   0
`define ICFGT_GEN_FLIP      2
`define ICFGT_GEN_HPDOVR    3
`define ICFGT_GEN_EQOVR     4
`define ICFGT_GEN_HPDSWAP   5

// reset values
`define ICFGT_GEN_RST       6'h01
`define ICFGT_EQ_RST        8'h00
`define ICFGT_EVT_RST       8'h00

// upper five target address bits per high-strap level
`define ICFGT_AHI_LVL0      5'h11
`define ICFGT_AHI_LVLR      5'h08
`define ICFGT_AHI_LVLF      5'h04
`define ICFGT_AHI_LVL1      5'h03

`endif

// ==== rtl/icfgt_pkg.sv ====
// types shared by the configuration target and its bench
// assumes strap levels arrive already encoded as 0, R, F, 1 -> 0..3
package icfgt_pkg;

   // four-level strap code: 0=low, 1=R, 2=F, 3=high
   typedef logic [1:0] icfgt_level_t;

   // configuration straps sampled once after power-up
   typedef struct packed {
      logic         busMode;
      icfgt_level_t downstreamEq1;
      icfgt_level_t downstreamEq0;
      icfgt_level_t upstreamEq1;
      icfgt_level_t upstreamEqLowAddrLowStrap;
      icfgt_level_t displayEq1;
      icfgt_level_t displayEqLowAddrHighStrap;
   } icfgt_straps_s;

   // control outputs towards the datapath
   typedef struct packed {
      logic        powerGood;
      logic [1:0]  funcSel;
      logic        flip;
      logic        hpdOverride;
      logic        hpdSwap;
      logic [15:0] displayEq;
      logic [3:0]  upstreamEq;
      logic [3:0]  downstreamEq;
      logic [3:0]  swFlags;
   } icfgt_ctrl_s;

   // two-wire target states
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
      ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK, ST_IGNORE
   } icfgt_state_e;

endpackage : icfgt_pkg

// ==== rtl/icfgt_debounce.sv ====
// debouncer for the mode-control and orientation pins
// assumes asynchronous pins; two flops synchronise them before any logic
`timescale 1ns/1ps
`include "icfgt_cfg.svh"

module icfgt_debounce #(
   parameter int W      = 3,
   parameter int CYCLES = `ICFGT_DB_CYCLES
) (
   input  logic         clk,
   input  logic         rst,
   input  logic [W-1:0] pins,
   output logic [W-1:0] level
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [W-1:0]  sync1_q;
   logic [W-1:0]  sync2_q;
   logic [W-1:0]  level_q;
   logic [W-1:0]  level_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // count stable cycles; accept so the whole path stays within the limit
   always_comb begin
      level_d = level_q;
      cnt_d   = '0;
      if (sync2_q != level_q) begin
         if (cnt_q == CW'(CYCLES - `ICFGT_SYNC_LAT)) begin
            level_d = sync2_q;  // [R22]
         end else begin
            cnt_d = CW'(cnt_q + 1'b1);
         end
      end
   end

   // synchroniser and debounce state
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
         level_q <= '0;
         cnt_q   <= '0;
      end else begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         level_q <= level_d;
         cnt_q   <= cnt_d;
      end
   end

   assign level = level_q;

endmodule : icfgt_debounce

// ==== rtl/icfgt_target.sv ====
// two-wire configuration target with strap sampling and pin/register mode
// assumes pins are asynchronous to clk (40 MHz) and an open-drain data wire outside
`timescale 1ns/1ps
`include "icfgt_cfg.svh"

// How it works
// R01 - target address: five upper bits from high strap, two lower from low strap.
// R02 - write starts with start, address, direction zero; address is acknowledged.
// R03 - first write byte is the sub-address, acknowledged and loaded as pointer.
// R04 - further write bytes are stored and each one acknowledged.
// R05 - each stored byte advances the pointer by one.
// R06 - master closes every write with a stop.
// R07 - read starts with start, address, direction one; ack, then data MSB first.
// R08 - read starts at the pointer: zero, last read plus one, or written sub-address.
// R09 - after each sent byte the target waits for master ack or nack.
// R10 - on master ack the next register is sent.
// R11 - on nack the target releases data and waits for stop.
// R12 - master closes every read with a stop.
// R13 - a sub-address-only write sets where later reads start.
// R14 - reads advance one register per byte until the master ends them.
// R15 - set-type field goes to one on written one; zero does nothing.
// R16 - clear-type field goes to zero on written one; zero does nothing.
// R17 - update-type fields change from hardware on their own.
// R18 - internal power good rises no later than 500 us after reset.
// R19 - straps are stable 250 us before sampling.
// R20 - straps stay stable 10 us after sampling.
// R21 - sampled set is bus-mode strap and three equalizer strap pairs.
// R22 - control and orientation pins debounced, accepted within 16 ms.
// R23 - serial clock and data pins carry register access.
// R24 - bus-mode strap zero: pins select function; otherwise registers do.
module icfgt_target #(
   parameter int PG_CYCLES = `ICFGT_PG_CYCLES,
   parameter int SU_CYCLES = `ICFGT_SU_CYCLES,
   parameter int DB_CYCLES = `ICFGT_DB_CYCLES
) (
   input  logic                  clk,
   input  logic                  rst,
   input  icfgt_pkg::icfgt_straps_s strapPins,
   input  logic [1:0]            functionSelectPins,
   input  logic                  flipPin,
   input  logic                  scl,
   input  logic                  sdaIn,
   output logic                  sdaOut,
   output logic                  sdaOe,
   input  logic [3:0]            hwEvent,
   input  logic [6:0]            laneStatus,
   output icfgt_pkg::icfgt_ctrl_s ctrl
);
   localparam int PW = $clog2(PG_CYCLES + 1);

   icfgt_pkg::icfgt_straps_s strapS1_q;
   icfgt_pkg::icfgt_straps_s strapS2_q;
   icfgt_pkg::icfgt_straps_s straps_q;
   icfgt_pkg::icfgt_straps_s straps_d;
   icfgt_pkg::icfgt_ctrl_s   ctrl_q;
   icfgt_pkg::icfgt_ctrl_s   ctrl_d;
   icfgt_pkg::icfgt_state_e  state_q;
   icfgt_pkg::icfgt_state_e  state_d;
   logic [PW-1:0] pwrCnt_q;
   logic [PW-1:0] pwrCnt_d;
   logic          powerGood_q;
   logic          powerGood_d;
   logic [2:0]    dbLevel;
   logic          sclS1_q;
   logic          sclS2_q;
   logic          sclP_q;
   logic          sdaS1_q;
   logic          sdaS2_q;
   logic          sdaP_q;
   logic          sclRise;
   logic          sclFall;
   logic          startSeen;
   logic          stopSeen;
   logic [3:0]    bitCnt_q;
   logic [3:0]    bitCnt_d;
   logic [7:0]    shift_q;
   logic [7:0]    shift_d;
   logic [7:0]    ptr_q;
   logic [7:0]    ptr_d;
   logic          sdaOe_q;
   logic          sdaOe_d;
   logic          rnw_q;
   logic          rnw_d;
   logic          wrEn;
   logic [6:0]    devAddr;
   logic [4:0]    addrHigh;
   logic [7:0]    rdData;
   logic [5:0]    genReg_q;
   logic [5:0]    genReg_d;
   logic [7:0]    dpEq01_q;
   logic [7:0]    dpEq01_d;
   logic [7:0]    dpEq23_q;
   logic [7:0]    dpEq23_d;
   logic [7:0]    evt_q;
   logic [7:0]    evt_d;
   logic [3:0]    dispStrapEq;
   logic [7:0]    dpEq01Eff;
   logic [7:0]    dpEq23Eff;

   // pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         strapS1_q <= '0;
         strapS2_q <= '0;
         sclS1_q   <= 1'b1;
         sclS2_q   <= 1'b1;
         sclP_q    <= 1'b1;
         sdaS1_q   <= 1'b1;
         sdaS2_q   <= 1'b1;
         sdaP_q    <= 1'b1;
      end else begin
         strapS1_q <= strapPins;
         strapS2_q <= strapS1_q;
         sclS1_q   <= scl;      // [R23]
         sclS2_q   <= sclS1_q;
         sclP_q    <= sclS2_q;
         sdaS1_q   <= sdaIn;
         sdaS2_q   <= sdaS1_q;
         sdaP_q    <= sdaS2_q;
      end
   end

   // bus events from the synchronised wires
   assign sclRise   = sclS2_q & ~sclP_q;
   assign sclFall   = ~sclS2_q & sclP_q;
   assign startSeen = sclS2_q & sclP_q & sdaP_q & ~sdaS2_q;
   assign stopSeen  = sclS2_q & sclP_q & ~sdaP_q & sdaS2_q;

   // power-good timer and one-time strap capture
   always_comb begin
      pwrCnt_d    = pwrCnt_q;
      powerGood_d = powerGood_q;
      straps_d    = straps_q;
      if (!powerGood_q) begin
         pwrCnt_d = PW'(pwrCnt_q + 1'b1);
      end
      if (!powerGood_q && pwrCnt_q == PW'(SU_CYCLES - 1)) begin
         straps_d = strapS2_q;  // [R19] [R21]
      end
      if (pwrCnt_q == PW'(PG_CYCLES - 1)) begin
         powerGood_d = 1'b1;    // [R18]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pwrCnt_q    <= '0;
         powerGood_q <= 1'b0;
         straps_q    <= '0;
      end else begin
         pwrCnt_q    <= pwrCnt_d;
         powerGood_q <= powerGood_d;
         straps_q    <= straps_d;
      end
   end

   // control and orientation pin debouncer
   icfgt_debounce #(
      .W      (3),
      .CYCLES (DB_CYCLES)
   ) u_debounce (
      .clk   (clk),
      .rst   (rst),
      .pins  ({flipPin, functionSelectPins}),
      .level (dbLevel)
   );

   // target address from the two address straps
   always_comb begin
      unique case (straps_q.displayEqLowAddrHighStrap)
         2'h0: addrHigh = `ICFGT_AHI_LVL0;
         2'h1: addrHigh = `ICFGT_AHI_LVLR;
         2'h2: addrHigh = `ICFGT_AHI_LVLF;
         2'h3: addrHigh = `ICFGT_AHI_LVL1;
      endcase
   end
   assign devAddr = {addrHigh, straps_q.upstreamEqLowAddrLowStrap};  // [R01]

   // equalizer fields show straps unless software overrides them
   assign dispStrapEq = {straps_q.displayEq1, straps_q.displayEqLowAddrHighStrap};
   assign dpEq01Eff = genReg_q[`ICFGT_GEN_EQOVR] ? dpEq01_q : {2{dispStrapEq}};  // [R17]
   assign dpEq23Eff = genReg_q[`ICFGT_GEN_EQOVR] ? dpEq23_q : {2{dispStrapEq}};

   // register read mux; unmapped offsets read zero
   always_comb begin
      unique case (ptr_q)
         `ICFGT_OFS_GENERAL: rdData = {2'h0, genReg_q};
         `ICFGT_OFS_DPEQ01:  rdData = dpEq01Eff;
         `ICFGT_OFS_DPEQ23:  rdData = dpEq23Eff;
         `ICFGT_OFS_LSTAT:   rdData = {1'b0, laneStatus};  // [R17]
         `ICFGT_OFS_EVENT:   rdData = evt_q;
         default:            rdData = 8'h00;
      endcase
   end

   // two-wire target sequencer
   always_comb begin
      state_d  = state_q;
      bitCnt_d = bitCnt_q;
      shift_d  = shift_q;
      ptr_d    = ptr_q;
      sdaOe_d  = sdaOe_q;
      rnw_d    = rnw_q;
      wrEn     = 1'b0;
      if (!powerGood_q || stopSeen) begin
         state_d = icfgt_pkg::ST_IDLE;  // [R06] [R12]
         sdaOe_d = 1'b0;
      end else if (startSeen) begin
         state_d  = icfgt_pkg::ST_ADDR;
         bitCnt_d = 4'h0;
         sdaOe_d  = 1'b0;
      end else begin
         unique case (state_q)
            icfgt_pkg::ST_IDLE, icfgt_pkg::ST_IGNORE: begin
            end
            icfgt_pkg::ST_ADDR, icfgt_pkg::ST_SUB, icfgt_pkg::ST_WR: begin
               if (sclRise) begin
                  shift_d  = {shift_q[6:0], sdaS2_q};  // msb first
                  bitCnt_d = bitCnt_q + 4'h1;
               end
               if (sclFall && bitCnt_q == 4'h8) begin
                  bitCnt_d = 4'h0;
                  sdaOe_d  = 1'b1;
                  if (state_q == icfgt_pkg::ST_ADDR) begin
                     if (shift_q[7:1] == devAddr) begin
                        rnw_d   = shift_q[0];
                        state_d = icfgt_pkg::ST_ADDR_ACK;  // [R02] [R07]
                     end else begin
                        sdaOe_d = 1'b0;
                        state_d = icfgt_pkg::ST_IGNORE;
                     end
                  end else if (state_q == icfgt_pkg::ST_SUB) begin
                     ptr_d   = shift_q;                  // [R03] [R13]
                     state_d = icfgt_pkg::ST_SUB_ACK;
                  end else begin
                     wrEn    = 1'b1;                     // [R04]
                     ptr_d   = ptr_q + 8'h01;            // [R05]
                     state_d = icfgt_pkg::ST_WR_ACK;
                  end
               end
            end
            icfgt_pkg::ST_ADDR_ACK, icfgt_pkg::ST_SUB_ACK, icfgt_pkg::ST_WR_ACK: begin
               if (sclFall) begin
                  if (state_q == icfgt_pkg::ST_ADDR_ACK && rnw_q) begin
                     shift_d  = rdData;                  // [R08]
                     ptr_d    = ptr_q + 8'h01;
                     sdaOe_d  = ~rdData[7];
                     bitCnt_d = 4'h0;
                     state_d  = icfgt_pkg::ST_RD;
                  end else begin
                     sdaOe_d = 1'b0;
                     state_d = (state_q == icfgt_pkg::ST_ADDR_ACK) ?
                               icfgt_pkg::ST_SUB : icfgt_pkg::ST_WR;
                  end
               end
            end
            icfgt_pkg::ST_RD: begin
               if (sclFall) begin
                  if (bitCnt_q == 4'h7) begin
                     sdaOe_d  = 1'b0;                    // [R09]
                     bitCnt_d = 4'h0;
                     state_d  = icfgt_pkg::ST_RD_ACK;
                  end else begin
                     shift_d  = {shift_q[6:0], 1'b0};
                     sdaOe_d  = ~shift_q[6];
                     bitCnt_d = bitCnt_q + 4'h1;
                  end
               end
            end
            icfgt_pkg::ST_RD_ACK: begin
               if (sclRise) begin
                  if (sdaS2_q) begin
                     state_d = icfgt_pkg::ST_IGNORE;     // [R11]
                  end else begin
                     bitCnt_d = 4'h1;                    // ack seen
                  end
               end else if (sclFall && bitCnt_q == 4'h1) begin
                  shift_d  = rdData;                     // [R10] [R14]
                  ptr_d    = ptr_q + 8'h01;
                  sdaOe_d  = ~rdData[7];
                  bitCnt_d = 4'h0;
                  state_d  = icfgt_pkg::ST_RD;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q  <= icfgt_pkg::ST_IDLE;
         bitCnt_q <= 4'h0;
         shift_q  <= 8'h00;
         ptr_q    <= 8'h00;
         sdaOe_q  <= 1'b0;
         rnw_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         bitCnt_q <= bitCnt_d;
         shift_q  <= shift_d;
         ptr_q    <= ptr_d;
         sdaOe_q  <= sdaOe_d;
         rnw_q    <= rnw_d;
      end
   end

   // register file writes and hardware updates
   always_comb begin
      genReg_d = genReg_q;
      dpEq01_d = dpEq01_q;
      dpEq23_d = dpEq23_q;
      evt_d    = evt_q;
      if (wrEn) begin
         unique case (ptr_q)
            `ICFGT_OFS_GENERAL: genReg_d = shift_q[5:0];
            `ICFGT_OFS_DPEQ01:  dpEq01_d = shift_q;
            `ICFGT_OFS_DPEQ23:  dpEq23_d = shift_q;
            `ICFGT_OFS_EVENT: begin
               evt_d[7:4] = evt_q[7:4] | shift_q[7:4];   // [R15]
               evt_d[3:0] = evt_q[3:0] & ~shift_q[3:0];  // [R16]
            end
            default: begin
            end
         endcase
      end
      evt_d[3:0] = evt_d[3:0] | hwEvent;  // set beats clear [R17]
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         genReg_q <= `ICFGT_GEN_RST;
         dpEq01_q <= `ICFGT_EQ_RST;
         dpEq23_q <= `ICFGT_EQ_RST;
         evt_q    <= `ICFGT_EVT_RST;
      end else begin
         genReg_q <= genReg_d;
         dpEq01_q <= dpEq01_d;
         dpEq23_q <= dpEq23_d;
         evt_q    <= evt_d;
      end
   end

   // control outputs: pin mode or register mode
   always_comb begin
      ctrl_d              = '0;
      ctrl_d.powerGood    = powerGood_q;
      ctrl_d.displayEq    = {dpEq23Eff, dpEq01Eff};
      ctrl_d.upstreamEq   = {straps_q.upstreamEq1, straps_q.upstreamEqLowAddrLowStrap};
      ctrl_d.downstreamEq = {straps_q.downstreamEq1, straps_q.downstreamEq0};
      ctrl_d.swFlags      = evt_q[7:4];
      ctrl_d.hpdOverride  = genReg_q[`ICFGT_GEN_HPDOVR];
      ctrl_d.hpdSwap      = genReg_q[`ICFGT_GEN_HPDSWAP];
      if (powerGood_q) begin
         if (!straps_q.busMode) begin
            ctrl_d.funcSel = dbLevel[1:0];  // [R24]
            ctrl_d.flip    = dbLevel[2];
         end else begin
            ctrl_d.funcSel = genReg_q[`ICFGT_GEN_CTL_LSB +: 2];  // [R24]
            ctrl_d.flip    = genReg_q[`ICFGT_GEN_FLIP];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   assign ctrl   = ctrl_q;
   assign sdaOe  = sdaOe_q;  // open drain: pulls low while enabled
   assign sdaOut = 1'b0;

endmodule : icfgt_target

// ==== verification/icfgt_target_checker.sv ====
// assertions on the configuration target's pins and control outputs
// assumes binding into icfgt_target and straps held steady between resets
`timescale 1ns/1ps
module icfgt_target_checker #(
   parameter int PG_CYCLES = 40,
   parameter int DB_CYCLES = 16
) (
   input logic                     clk,
   input logic                     rst,
   input icfgt_pkg::icfgt_straps_s strapPins,
   input logic [1:0]               functionSelectPins,
   input logic                     flipPin,
   input logic                     scl,
   input logic                     sdaOut,
   input logic                     sdaOe,
   input icfgt_pkg::icfgt_ctrl_s   ctrl
);
   logic [15:0] upCnt_q;
   logic [15:0] upCnt_d;
   logic [15:0] pinCnt_q;
   logic [15:0] pinCnt_d;
   logic [2:0]  pinsLast_q;

   // cycles since reset release and cycles of steady control pins
   always_comb begin
      upCnt_d = upCnt_q + 16'h0001;
      pinCnt_d = pinCnt_q + 16'h0001;
      if ({functionSelectPins, flipPin} != pinsLast_q) pinCnt_d = 16'h0000;
      if (rst) begin
         upCnt_d = 16'h0000;
         pinCnt_d = 16'h0000;
      end
   end
   // counter registers
   always_ff @(posedge clk) begin
      upCnt_q <= upCnt_d;
      pinCnt_q <= pinCnt_d;
      pinsLast_q <= {functionSelectPins, flipPin};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_RST_QUIET: assert property (disable iff (1'b0) rst |=> ctrl == '0 && !sdaOe)
      else $error("outputs not cleared by reset");
   AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
      else $error("data pin driven high");
   AST_OE_SCL_LOW: assert property ($changed(sdaOe) |-> !$past(scl))
      else $error("data pull changed while bus clock high");
   AST_NO_BUS: assert property (!ctrl.powerGood |-> !sdaOe)
      else $error("bus answered before power good");
   AST_PG_STAYS: assert property (ctrl.powerGood |=> ctrl.powerGood)
      else $error("power good dropped");
   AST_PIN_GATE: assert property (!ctrl.powerGood |-> ctrl.funcSel == 2'h0 && !ctrl.flip)
      else $error("function enabled before power good");
   AST_PG_TIME: assert property ($rose(ctrl.powerGood) |-> int'(upCnt_q) == PG_CYCLES + 1)
      else $error("power good at wrong cycle");
   AST_DB_TIME: assert property (ctrl.powerGood && !strapPins.busMode &&
      int'(pinCnt_q) >= DB_CYCLES + 2 |-> {ctrl.funcSel, ctrl.flip} == pinsLast_q)
      else $error("control pins not followed in time");
endmodule : icfgt_target_checker

// ==== verification/icfgt_bus_master.sv ====
// two-wire bus master model: clock and its pull on the data wire
// assumes a pulled-up data wire that the target pulls low through sdaOe
`timescale 1ns/1ps
module icfgt_bus_master (
   input  logic clk,
   input  logic sdaOe,
   output logic scl,
   output logic sdaWire
);
   logic mPull;

   // wired level of both pull-downs over the pull-up
   assign sdaWire = ~(sdaOe | mPull);
   initial begin
      scl = 1'b1;
      mPull = 1'b0;
   end
   // half a bus clock period, 100 ns
   task automatic half();
      repeat (4) @(negedge clk);
   endtask : half
   // start: data falls while the clock is high
   task automatic startC();
      mPull = 1'b0;
      half();
      scl = 1'b1;
      half();
      mPull = 1'b1;
      half();
      scl = 1'b0;
      @(negedge clk);
   endtask : startC
   // stop: data rises while the clock is high
   task automatic stopC();
      mPull = 1'b1;
      half();
      scl = 1'b1;
      half();
      mPull = 1'b0;
      half();
   endtask : stopC
   // one bit: set while clock low, sampled at the end of clock high
   task automatic bitX(input logic b, output logic v);
      mPull = ~b;
      half();
      scl = 1'b1;
      half();
      v = sdaWire;
      scl = 1'b0;
      @(negedge clk);
   endtask : bitX
   // byte out MSB first, ninth clock reads the acknowledge
   task automatic wrByte(input logic [7:0] b, output logic ack);
      logic v;
      for (int i = 7; i >= 0; i--) bitX(b[i], v);
      bitX(1'b1, v);
      ack = ~v;
   endtask : wrByte
   // byte in MSB first, then acknowledge to go on or not to end
   task automatic rdByte(input logic more, output logic [7:0] d);
      logic v;
      for (int i = 7; i >= 0; i--) begin
         bitX(1'b1, v);
         d[i] = v;
      end
      bitX(~more, v);
   endtask : rdByte
endmodule : icfgt_bus_master

// ==== verification/icfgt_target_tb.sv ====
// bench: address straps, pin mode, register traffic over the two-wire bus
// assumes the bus master model and short power and debounce counts
`timescale 1ns/1ps
module icfgt_target_tb;
   localparam int PG = 40;
   localparam int DB = 16;
   logic clk, rst, scl, sdaWire, sdaOut, sdaOe, flipPin, ack;
   logic [1:0] functionSelectPins;
   logic [3:0] hwEvent;
   logic [6:0] laneStatus;
   logic [6:0] addr;
   logic [7:0] d;
   icfgt_pkg::icfgt_straps_s strapPins;
   icfgt_pkg::icfgt_ctrl_s ctrl;
   int miscompares;
   int checks;
   logic [4:0] hiBits [4] = '{5'h11, 5'h08, 5'h04, 5'h03};

   icfgt_target #(.PG_CYCLES(PG), .SU_CYCLES(20), .DB_CYCLES(DB)) dut (
      .clk(clk), .rst(rst), .strapPins(strapPins), .functionSelectPins(functionSelectPins),
      .flipPin(flipPin), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .hwEvent(hwEvent), .laneStatus(laneStatus), .ctrl(ctrl));
   icfgt_bus_master m (.clk(clk), .sdaOe(sdaOe), .scl(scl), .sdaWire(sdaWire));

   // 40 MHz clock
   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // reset 20 cycles with new straps, then a bounded wait for power good
   task automatic powerUp(input icfgt_pkg::icfgt_straps_s s);
      int n;
      @(negedge clk);
      strapPins = s;
      rst = 1'b1;
      repeat (20) @(negedge clk);
      rst = 1'b0;
      n = 0;
      while (ctrl.powerGood !== 1'b1 && n < 4 * PG) begin
         @(negedge clk);
         n++;
      end
      chk("power good delay", 16'(n), 16'(PG + 1));
      if (n >= 4 * PG) wrap_up();
   endtask : powerUp
   // write: address, sub-address, data bytes, each acknowledged
   task automatic wrRegs(input logic [7:0] q[$]);
      q.push_front({addr, 1'b0});
      m.startC();
      foreach (q[i]) begin
         m.wrByte(q[i], ack);
         chk("write ack", 16'(ack), 16'h0001);
      end
      m.stopC();
   endtask : wrRegs
   // read: last byte not acknowledged; tail clocks one byte more after that
   task automatic rdRegs(input logic [7:0] exp[$], input logic tail);
      m.startC();
      m.wrByte({addr, 1'b1}, ack);
      chk("read ack", 16'(ack), 16'h0001);
      foreach (exp[i]) begin
         m.rdByte(i < exp.size() - 1, d);
         chk("read data", 16'(d), 16'(exp[i]));
      end
      if (tail) begin
         m.rdByte(1'b0, d);
         chk("released line", 16'(d), 16'h00FF);
      end
      m.stopC();
   endtask : rdRegs

   initial begin
      icfgt_pkg::icfgt_straps_s s;
      rst = 1'b1;
      strapPins = '0;
      functionSelectPins = 2'h0;
      flipPin = 1'b0;
      hwEvent = 4'h0;
      laneStatus = 7'h5A;
      addr = 7'h00;
      miscompares = 0;
      checks = 0;
      // every address strap pair in pin mode, then the control pins
      for (int l = 0; l < 16; l++) begin
         s = '0;
         s.displayEqLowAddrHighStrap = 2'(l >> 2);
         s.upstreamEqLowAddrLowStrap = 2'(l);
         s.downstreamEq1 = 2'(l);
         powerUp(s);
         addr = {hiBits[l >> 2], 2'(l)};
         m.startC();
         m.wrByte({addr ^ 7'h40, 1'b0}, ack);
         m.stopC();
         chk("foreign address ack", 16'(ack), 16'h0000);
         wrRegs('{8'h0A});
         chk("downstream eq", 16'(ctrl.downstreamEq), 16'((l & 3) << 2));
         chk("upstream eq", 16'(ctrl.upstreamEq), 16'(l & 3));
         chk("display eq strap", 16'(ctrl.displayEq), 16'((l >> 2) * 16'h1111));
         functionSelectPins = 2'(l);
         flipPin = l[2];
         repeat (DB + 2) @(negedge clk);
         chk("pin select", 16'({ctrl.funcSel, ctrl.flip}), 16'({2'(l), l[2]}));
         $display("test straps %0d done", l);
      end
      // register mode at address 0010001
      s = '0;
      s.busMode = 1'b1;
      s.displayEqLowAddrHighStrap = 2'h2;
      s.upstreamEqLowAddrLowStrap = 2'h1;
      s.displayEq1 = 2'h3;
      powerUp(s);
      addr = 7'h11;
      chk("reset select", 16'({ctrl.funcSel, ctrl.flip}), 16'h0002);
      wrRegs('{8'h10});
      rdRegs('{8'hEE, 8'hEE, 8'h5A}, 1'b0);
      rdRegs('{8'h00}, 1'b0);
      wrRegs('{8'h0A, 8'h3E, 8'hFF});
      chk("reg select", 16'({ctrl.funcSel, ctrl.flip, ctrl.hpdOverride, ctrl.hpdSwap}),
          16'h0017);
      wrRegs('{8'h10, 8'hA5, 8'h5A, 8'h77});
      chk("display eq", 16'(ctrl.displayEq), 16'h5AA5);
      laneStatus = 7'h21;
      wrRegs('{8'h0A});
      rdRegs('{8'h3E, 0, 0, 0, 0, 0, 8'hA5, 8'h5A, 8'h21}, 1'b0);
      $display("test register burst done");
      // event flags: hardware sets, written ones set the high half, clear the low
      hwEvent = 4'h9;
      @(negedge clk);
      hwEvent = 4'h0;
      wrRegs('{8'h20});
      rdRegs('{8'h09}, 1'b0);
      wrRegs('{8'h20, 8'h61});
      chk("software flags", 16'(ctrl.swFlags), 16'h0006);
      wrRegs('{8'h20, 8'h00});
      wrRegs('{8'h20});
      rdRegs('{8'h68}, 1'b1);
      $display("test event flags done");
      wrap_up();
   end
endmodule : icfgt_target_tb

bind icfgt_target icfgt_target_checker #(.PG_CYCLES(PG_CYCLES), .DB_CYCLES(DB_CYCLES)) chk (
   .clk(clk), .rst(rst), .strapPins(strapPins), .functionSelectPins(functionSelectPins),
   .flipPin(flipPin), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe), .ctrl(ctrl));
